// ### logic/sram_params.svh
// Constants shared by the split-port double data rate memory design.
// Assumes it is included by bare name before any module that uses it.
`ifndef SRAM_PARAMS_SVH
`define SRAM_PARAMS_SVH
// Width of one byte lane of write data.
`define LANE_W 9
// Data widths of the narrow and wide configurations.
`define NARROW_DATA_W 18
`define WIDE_DATA_W 36
// Address widths of the narrow and wide configurations.
`define NARROW_ADDR_W 19
`define WIDE_ADDR_W 18
// Entries in the write queue.
`define WQ_DEPTH 32
`endif

// ### logic/sram_pkg.sv
// Types shared by the split-port double data rate memory design.
// Assumes nothing of its surroundings.
package sram_pkg;
	// Read output sequencer; IDLE, WORD0, WORD1 step through Gray codes.
	typedef enum logic [1:0] {
		RD_IDLE = 2'h0,
		RD_WORD0 = 2'h1,
		RD_WORD1 = 2'h3
	} rd_state_t;
endpackage : sram_pkg

// ### logic/stream_if.sv
// Valid and ready stream carrier between the core and its write queue.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface stream_if #(
	parameter int W = 8
);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	// Producing end.
	modport src(output valid, output data, input ready);
	// Consuming end.
	modport snk(input valid, input data, output ready);
endinterface : stream_if

// ### logic/pin_sync.sv
// Two flip-flop synchroniser for a bundle of pins from another clock domain.
// Assumes rst_n is already synchronous to clk.
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Raw pins and their synchronised copy.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// Only the second stage is read outside, so metastability cannot spread.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : pin_sync

// ### logic/wr_fifo.sv
// First-in first-out queue with valid and ready on both sides.
// Assumes DEPTH is a power of two and rst_n is synchronous to clk.
`timescale 1ns/1ps
module wr_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Filling and draining sides.
	stream_if.snk in_s,
	stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic full;
	logic empty;
	logic push;
	logic pop;

	// An extra pointer bit tells a full queue from an empty one.
	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign in_s.ready = !full;
	assign out_s.valid = !empty;
	assign out_s.data = mem[rd_ptr_r[AW-1:0]];
	assign push = in_s.valid && !full;
	assign pop = !empty && out_s.ready;

	// Storage holds no reset; only the pointers decide what is valid.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= in_s.data;
		end
	end

	// Pointer updates.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule : wr_fifo

// ### logic/split_port_ddr_sram.sv
// Split-port double data rate memory: pins sampled on the core clock.
// Assumes the link clocks run well below half the core clock rate.
// Assumes every request pin is steady for three core cycles around the link
// clock edge that samples it, since all pins share one synchroniser delay.
// Assumes the controller watches WRITE_READY; a burst that meets a full queue is dropped.
// A read of an address still waiting in the queue returns the older contents.
`timescale 1ns/1ps
`include "sram_params.svh"
module split_port_ddr_sram #(
	parameter bit WIDE = 1'b1,
	parameter int DATA_W = WIDE ? `WIDE_DATA_W : `NARROW_DATA_W,
	parameter int ADDR_W = WIDE ? `WIDE_ADDR_W : `NARROW_ADDR_W,
	parameter int WQ_DEPTH = `WQ_DEPTH
) (
	// Core clock and reset.
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// Link clocks from the controller.
	input wire logic K,
	input wire logic K_N,
	input wire logic C,
	input wire logic C_N,
	input wire logic SINGLE_CLK_MODE,
	// Request pins.
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [DATA_W-1:0] WR_DATA,
	input wire logic [DATA_W/`LANE_W-1:0] BYTE_LANE_WRITE_SELECT_N,
	input wire logic WRITE_PORT_SELECT_N,
	input wire logic READ_PORT_SELECT_N,
	// Read data pins.
	output logic [DATA_W-1:0] RD_DATA,
	output logic RD_DATA_OE,
	// Write queue room.
	output logic WRITE_READY
);
	localparam int LANES = DATA_W / `LANE_W;
	localparam int SYNC_W = 7 + ADDR_W + DATA_W + LANES;
	localparam int ENTRY_W = ADDR_W + 2 * (DATA_W + LANES);
	localparam int WORDS = 2 ** ADDR_W;

	// Reset release stages.
	logic rst_meta_r;
	logic rst_n_r;

	// Pins after the two synchroniser stages.
	logic [SYNC_W-1:0] sync_q;
	logic k_s;
	logic kn_s;
	logic c_s;
	logic cn_s;
	logic single_s;
	logic wps_n_s;
	logic rps_n_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] wdata_s;
	logic [LANES-1:0] bws_n_s;

	// Link clock edges; stage priming hides the zeros left by reset.
	logic [2:0] prime_r;
	logic [3:0] clk_s;
	logic [3:0] clk_q_r;
	logic [3:0] clk_rise;
	logic k_rise;
	logic kn_rise;
	logic pos_launch;
	logic neg_launch;

	// Write burst assembly.
	logic wr_open_r;
	logic [DATA_W-1:0] word0_r;
	logic [LANES-1:0] mask0_r;
	logic push_valid_r;
	logic [ENTRY_W-1:0] push_data_r;

	// Read fetch and burst delivery.
	logic fetch_r;
	logic [ADDR_W-1:0] rd_addr_r;
	logic pending_r;
	logic [DATA_W-1:0] hold_r;
	logic start_burst;
	logic next_word;
	logic end_burst;

	// Fields of the entry leaving the queue.
	logic drain;
	logic [ADDR_W-1:0] wa;
	logic [DATA_W-1:0] wd0;
	logic [DATA_W-1:0] wd1;
	logic [LANES-1:0] wm0;
	logic [LANES-1:0] wm1;

	// Array outputs of the addressed pair.
	wire logic [DATA_W-1:0] rd0_w;
	wire logic [DATA_W-1:0] rd1_w;

	// Output sequencer state.
	sram_pkg::rd_state_t state_r;

	// Write entries pass from burst assembly through the queue to the arrays.
	stream_if #(.W(ENTRY_W)) wq_in();
	stream_if #(.W(ENTRY_W)) wq_out();

	// Reset is asserted at once and released through two flip-flops.
	// Every other register with a reset in the block takes it from this released copy.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// Every pin passes the same two stages, so data stays aligned with clocks.
	pin_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk(CORE_CLK),
		.rst_n(rst_n_r),
		.d({K, K_N, C, C_N, SINGLE_CLK_MODE, WRITE_PORT_SELECT_N, READ_PORT_SELECT_N,
			ADDR, WR_DATA, BYTE_LANE_WRITE_SELECT_N}),
		.q(sync_q)
	);

	assign {k_s, kn_s, c_s, cn_s, single_s, wps_n_s, rps_n_s, addr_s, wdata_s, bws_n_s} = sync_q;

	// Link clock levels, K in the top bit down to C_N in the bottom bit.
	assign clk_s = {k_s, kn_s, c_s, cn_s};

	// The stages hold zeros just after reset, so a clock pin idling high would
	// look like a rising edge; edges count only once three real samples are in.
	always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			prime_r <= 3'h0;
		end else begin
			prime_r <= {prime_r[1:0], 1'b1};
		end
	end

	// Previous clock levels for edge detection.
	always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			clk_q_r <= 4'h0;
		end else begin
			clk_q_r <= clk_s;
		end
	end

	// One rising-edge detector per link clock.
	for (genvar i = 0; i < 4; i++) begin : g_edge
		assign clk_rise[i] = prime_r[2] && clk_s[i] && !clk_q_r[i];
	end

	// In single clock mode the input pair also launches read data.
	assign k_rise = clk_rise[3];
	assign kn_rise = clk_rise[2];
	assign pos_launch = single_s ? clk_rise[3] : clk_rise[1];
	assign neg_launch = single_s ? clk_rise[2] : clk_rise[0];

	// First half of a write burst is taken on the positive input rise.
	// A burst is opened only with queue room, so its later push never overflows.
	always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wr_open_r <= 1'b0;
			word0_r <= '0;
			mask0_r <= '1;
		end else if (k_rise) begin
			wr_open_r <= !wps_n_s && wq_in.ready;
			if (!wps_n_s) begin
				word0_r <= wdata_s;
				mask0_r <= bws_n_s;
			end
		end else if (kn_rise) begin
			wr_open_r <= 1'b0;
		end
	end

	// Second half and the write address complete the burst on the negative rise.
	always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			push_valid_r <= 1'b0;
			push_data_r <= '0;
		end else begin
			push_valid_r <= kn_rise && wr_open_r;
			if (kn_rise && wr_open_r) begin
				push_data_r <= {addr_s, word0_r, mask0_r, wdata_s, bws_n_s};
			end
		end
	end

	// The assembled entry is offered for one cycle only; room was checked when the
	// burst opened, so the queue never refuses it.
	assign wq_in.valid = push_valid_r;
	assign wq_in.data = push_data_r;
	assign WRITE_READY = wq_in.ready;

	// Queue between the write pins and the arrays.
	// Its depth bounds how many writes may wait behind a run of reads.
	wr_fifo #(
		.W(ENTRY_W),
		.DEPTH(WQ_DEPTH)
	) u_wq (
		.clk(CORE_CLK),
		.rst_n(rst_n_r),
		.in_s(wq_in.snk),
		.out_s(wq_out.src)
	);

	// A read fetch owns the arrays for its cycle, so the queue waits then.
	// Entries apply in arrival order, so a later burst to one address wins.
	assign wq_out.ready = !fetch_r;
	assign drain = wq_out.valid && !fetch_r;
	assign {wa, wd0, wm0, wd1, wm1} = wq_out.data;

	// Read address is taken on the positive input rise when selected.
	// The arrays are read one cycle later; the pair then waits for a launch edge.
	always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			fetch_r <= 1'b0;
			rd_addr_r <= '0;
		end else begin
			fetch_r <= k_rise && !rps_n_s;
			if (k_rise && !rps_n_s) begin
				rd_addr_r <= addr_s;
			end
		end
	end

	// Each lane has its own pair of arrays, one for each word of a burst.
	// The arrays hold no reset, so a read of a never-written pair returns unknowns.
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [`LANE_W-1:0] arr0 [WORDS];
		logic [`LANE_W-1:0] arr1 [WORDS];
		logic [`LANE_W-1:0] rd0_r;
		logic [`LANE_W-1:0] rd1_r;

		// A high lane select leaves the stored byte alone.
		always_ff @(posedge CORE_CLK) begin
			if (drain) begin
				if (!wm0[l]) begin
					arr0[wa] <= wd0[l*`LANE_W +: `LANE_W];
				end
				if (!wm1[l]) begin
					arr1[wa] <= wd1[l*`LANE_W +: `LANE_W];
				end
			end
		end

		// Both words of the addressed pair are read together.
		always_ff @(posedge CORE_CLK) begin
			if (fetch_r) begin
				rd0_r <= arr0[rd_addr_r];
				rd1_r <= arr1[rd_addr_r];
			end
		end

		assign rd0_w[l*`LANE_W +: `LANE_W] = rd0_r;
		assign rd1_w[l*`LANE_W +: `LANE_W] = rd1_r;
	end

	// A fetched pair waits for the next positive launch edge.
	// A fetch wins over the clear, so a read arriving at launch is not lost.
	always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pending_r <= 1'b0;
		end else if (fetch_r) begin
			pending_r <= 1'b1;
		end else if (pos_launch && state_r != sram_pkg::RD_WORD0) begin
			pending_r <= 1'b0;
		end
	end

	// Output sequencer: word one, then word two, then float or next burst.
	// WORD1 goes straight on to WORD0 when another read is pending, so
	// back-to-back bursts keep the drivers on without a gap.
	always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= sram_pkg::RD_IDLE;
		end else begin
			unique case (state_r)
				sram_pkg::RD_IDLE, sram_pkg::RD_WORD1: begin
					if (pos_launch) begin
						state_r <= pending_r ? sram_pkg::RD_WORD0 : sram_pkg::RD_IDLE;
					end
				end
				sram_pkg::RD_WORD0: begin
					if (neg_launch) begin
						state_r <= sram_pkg::RD_WORD1;
					end
				end
				default: begin
					state_r <= sram_pkg::RD_IDLE;
				end
			endcase
		end
	end

	// Launch decisions shared by the data register.
	assign start_burst = pos_launch && pending_r && state_r != sram_pkg::RD_WORD0;
	assign next_word = neg_launch && state_r == sram_pkg::RD_WORD0;
	assign end_burst = pos_launch && !pending_r && state_r == sram_pkg::RD_WORD1;

	// Read data comes from flip-flops; the second word is held at launch
	// so that a following fetch cannot disturb a burst under way.
	// Clearing the word as the drivers turn off keeps a floated bus at zero.
	always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			RD_DATA <= '0;
			hold_r <= '0;
		end else if (start_burst) begin
			RD_DATA <= rd0_w;
			hold_r <= rd1_w;
		end else if (next_word) begin
			RD_DATA <= hold_r;
		end else if (end_burst) begin
			RD_DATA <= '0;
		end
	end

	// Drivers are on only while a burst word is on the pins.
	// It is decoded from the state register, so it never glitches on a launch edge.
	assign RD_DATA_OE = (state_r != sram_pkg::RD_IDLE);
endmodule : split_port_ddr_sram

// ### verif/split_port_ddr_sram_properties.sv
// Pin-level checker for the split-port memory, bound to its top module.
// Assumes the positive clock pins idle low and the negative ones high between frames.
`timescale 1ns/1ps
module split_port_ddr_sram_properties #(
	parameter int DATA_W = 36
) (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// Link pins.
	input wire logic K,
	input wire logic K_N,
	input wire logic C,
	input wire logic C_N,
	input wire logic SINGLE_CLK_MODE,
	input wire logic WRITE_PORT_SELECT_N,
	input wire logic READ_PORT_SELECT_N,
	// Outputs.
	input wire logic [DATA_W-1:0] RD_DATA,
	input wire logic RD_DATA_OE,
	input wire logic WRITE_READY
);
	logic pos_r, neg_r, k_r;
	logic [7:0] since_pos_r, since_any_r, rd_age_r, wr_age_r;
	wire pos = SINGLE_CLK_MODE ? K : C;
	wire neg = SINGLE_CLK_MODE ? K_N : C_N;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	function automatic logic [7:0] inc(input logic [7:0] v);
		return (v == 8'hFF) ? v : v + 8'h01;
	endfunction : inc
	// Ages of raw pin events in core cycles; they saturate so long idle never wraps.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			{pos_r, neg_r, k_r} <= 3'h0;
			{since_pos_r, since_any_r, rd_age_r, wr_age_r} <= {4{8'hFF}};
		end else begin
			{pos_r, neg_r, k_r} <= {pos, neg, K};
			since_pos_r <= (pos && !pos_r) ? 8'h00 : inc(since_pos_r);
			since_any_r <= ((pos && !pos_r) || (neg && !neg_r)) ? 8'h00 : inc(since_any_r);
			rd_age_r <= (K && !k_r && !READ_PORT_SELECT_N) ? 8'h00 : inc(rd_age_r);
			wr_age_r <= (K && !k_r && !WRITE_PORT_SELECT_N) ? 8'h00 : inc(wr_age_r);
		end
	end
	a_reset_quiet: assert property ($rose(RESET_N) |-> !RD_DATA_OE && WRITE_READY)
		else $error("outputs active after reset");
	a_idle_zero: assert property (!RD_DATA_OE |-> RD_DATA == '0)
		else $error("read data not idle while floated");
	a_oe_launch: assert property ($rose(RD_DATA_OE) |-> since_pos_r <= 8'h08)
		else $error("read data driven without a launch edge");
	a_read_cause: assert property ($rose(RD_DATA_OE) |-> rd_age_r <= 8'h3C)
		else $error("read data driven without a read request");
	a_word_stable: assert property (RD_DATA_OE && since_any_r >= 8'h07 |-> $stable(RD_DATA))
		else $error("read word changed between launch edges");
	a_oe_drop: assert property ($fell(RD_DATA_OE) |-> since_pos_r <= 8'h08)
		else $error("outputs floated away from a launch edge");
	a_burst_hold: assert property ($rose(RD_DATA_OE) |-> RD_DATA_OE [*8])
		else $error("read burst cut short");
	a_full_cause: assert property ($fell(WRITE_READY) |-> wr_age_r <= 8'h3C)
		else $error("queue filled without a write");
endmodule : split_port_ddr_sram_properties

// ### verif/sram_ctrl_model.sv
// Controller model: drives both ports and the clock pairs, samples read words.
// Assumes every call starts on a core clock rising edge.
`timescale 1ns/1ps
`include "sram_params.svh"
module sram_ctrl_model #(
	parameter int DATA_W = 36,
	parameter int ADDR_W = 18
) (
	// Pacing clock and mode.
	input wire logic clk,
	input wire logic single,
	// Clock pairs.
	output logic k,
	output logic k_n,
	output logic c,
	output logic c_n,
	// Request pins.
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] wr_data,
	output logic [DATA_W/`LANE_W-1:0] byte_lane_write_select_n,
	output logic write_port_select_n,
	output logic read_port_select_n,
	// Read side.
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic rd_oe
);
	localparam int LW = DATA_W / `LANE_W;
	logic [DATA_W-1:0] w [4];
	logic oe [4];
	// Clocks idle with the positive phase low; selects idle inactive.
	initial begin
		{k, k_n, c, c_n} = 4'h5;
		{write_port_select_n, read_port_select_n} = 2'h3;
		addr = '0;
		wr_data = '0;
		byte_lane_write_select_n = '1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	// One 16-cycle input clock period; each pin is steady three or more cycles around its edge.
	task automatic frame(input bit rd, input bit wr, input logic [ADDR_W-1:0] ra, wa,
		input logic [DATA_W-1:0] d0, d1, input logic [LW-1:0] l0, l1);
		read_port_select_n <= !rd;
		write_port_select_n <= !wr;
		{addr, wr_data, byte_lane_write_select_n} <= {ra, d0, l0};
		wt(4);
		{k, k_n} <= 2'h2;
		wt(4);
		{write_port_select_n, read_port_select_n} <= 2'h3;
		{addr, wr_data, byte_lane_write_select_n} <= {wa, d1, l1};
		wt(4);
		{k, k_n} <= 2'h1;
		wt(3);
		// Released lines show the inverse, so a stale sample cannot pass.
		{addr, wr_data, byte_lane_write_select_n} <= ~{wa, d1, l1};
		wt(1);
	endtask : frame
	// Four launch halves on C or, in single clock mode, on K; words sampled late in each half.
	task automatic launch();
		for (int i = 0; i < 4; i++) begin
			if (single) begin
				{k, k_n} <= {!i[0], i[0]};
			end else begin
				{c, c_n} <= {!i[0], i[0]};
			end
			wt(7);
			@(negedge clk);
			w[i] = rd_data;
			oe[i] = rd_oe;
			wt(1);
		end
	endtask : launch
endmodule : sram_ctrl_model

// ### verif/tb_split_port_ddr_sram.sv
// Self-checking bench: each scenario drives the controller model and judges the reads.
// Assumes the design's default wide configuration.
`timescale 1ns/1ps
`include "sram_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD %0t got %h expected %h", $time, g, e); end end
module tb_split_port_ddr_sram;
	localparam int DW = 36;
	localparam int AW = 18;
	localparam logic [DW-1:0] D0 = 36'h123456789;
	localparam logic [DW-1:0] D1 = 36'hFEDCBA987;
	logic CORE_CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic SINGLE_CLK_MODE = 1'b0;
	wire K, K_N, C, C_N, WPS_N, RPS_N, OE, RDY;
	wire [AW-1:0] ADDR;
	wire [DW-1:0] WR_DATA, RD_DATA;
	wire [DW/`LANE_W-1:0] LANES_N;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;
	split_port_ddr_sram dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .K(K), .K_N(K_N), .C(C),
		.C_N(C_N), .SINGLE_CLK_MODE(SINGLE_CLK_MODE), .ADDR(ADDR), .WR_DATA(WR_DATA),
		.BYTE_LANE_WRITE_SELECT_N(LANES_N), .WRITE_PORT_SELECT_N(WPS_N),
		.READ_PORT_SELECT_N(RPS_N), .RD_DATA(RD_DATA), .RD_DATA_OE(OE), .WRITE_READY(RDY));
	sram_ctrl_model m (.clk(CORE_CLK), .single(SINGLE_CLK_MODE), .k(K), .k_n(K_N), .c(C),
		.c_n(C_N), .addr(ADDR), .wr_data(WR_DATA), .byte_lane_write_select_n(LANES_N),
		.write_port_select_n(WPS_N), .read_port_select_n(RPS_N), .rd_data(RD_DATA),
		.rd_oe(OE));
	initial begin
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	// A hang is cut short well past the expected run of about 600 cycles.
	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles == 4000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic final_report();
		if (fail_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report
	// Launches the burst already requested and checks both words and the float after it.
	task automatic burst(input logic [DW-1:0] e0, e1);
		m.launch();
		`CHK(m.oe[0], 1'b1)
		`CHK(m.w[0], e0)
		`CHK(m.w[1], e1)
		`CHK(m.oe[2], 1'b0)
		`CHK(m.w[2], '0)
	endtask : burst
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e0, e1);
		m.frame(1'b1, 1'b0, a, '0, '0, '0, '1, '1);
		burst(e0, e1);
	endtask : rd
	task automatic t_basic();
		m.frame(1'b0, 1'b1, '0, 18'h15A5A, D0, D1, '0, '0);
		rd(18'h15A5A, D0, D1);
	endtask : t_basic
	// Word 0 writes only lane i, word 1 writes all lanes but i.
	task automatic t_lanes();
		logic [DW-1:0] e0, e1, q0, q1, mk;
		logic [3:0] one;
		e0 = D0;
		e1 = D1;
		m.frame(1'b0, 1'b1, '0, 18'h00300, e0, e1, '0, '0);
		for (int i = 0; i < 4; i++) begin
			one = 4'h1 << i;
			mk = 36'h1FF << (9 * i);
			q0 = 36'hA5A5A5A5A + DW'(i);
			q1 = 36'h5A5A5A5A5 - DW'(i);
			m.frame(1'b0, 1'b1, '0, 18'h00300, q0, q1, ~one, one);
			e0 = (e0 & ~mk) | (q0 & mk);
			e1 = (q1 & ~mk) | (e1 & mk);
			rd(18'h00300, e0, e1);
		end
	endtask : t_lanes
	// Data and address on a deselected frame must change nothing and start no burst.
	task automatic t_deselect();
		m.frame(1'b0, 1'b0, 18'h15A5A, 18'h15A5A, ~D0, ~D1, '0, '0);
		m.launch();
		`CHK(m.oe[0], 1'b0)
		rd(18'h15A5A, D0, D1);
	endtask : t_deselect
	// Read one address and write another in the same period on the shared bus.
	task automatic t_concurrent();
		m.frame(1'b1, 1'b1, 18'h15A5A, 18'h3FFFF, ~D1, ~D0, '0, '0);
		burst(D0, D1);
		rd(18'h3FFFF, ~D1, ~D0);
	endtask : t_concurrent
	task automatic t_single();
		SINGLE_CLK_MODE <= 1'b1;
		m.wt(4);
		rd(18'h3FFFF, ~D1, ~D0);
		SINGLE_CLK_MODE <= 1'b0;
		m.wt(4);
	endtask : t_single
	initial begin
		repeat (5) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		m.wt(4);
		t_basic();
		t_lanes();
		t_deselect();
		t_concurrent();
		t_single();
		final_report();
	end
endmodule : tb_split_port_ddr_sram
bind split_port_ddr_sram split_port_ddr_sram_properties #(.DATA_W(DATA_W)) chk (
	.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .K(K), .K_N(K_N), .C(C), .C_N(C_N),
	.SINGLE_CLK_MODE(SINGLE_CLK_MODE), .WRITE_PORT_SELECT_N(WRITE_PORT_SELECT_N),
	.READ_PORT_SELECT_N(READ_PORT_SELECT_N), .RD_DATA(RD_DATA), .RD_DATA_OE(RD_DATA_OE),
	.WRITE_READY(WRITE_READY));
